// file: core/cstb_defs.vh
// register map, field positions, reset values and codes of the cap sense time base
`ifndef CSTB_DEFS_VH
`define CSTB_DEFS_VH

`define CSTB_ADDR_W       8
`define CSTB_OFF_PTCTL    8'h00
`define CSTB_OFF_PERIOD   8'h04
`define CSTB_OFF_COUNT    8'h08
`define CSTB_OFF_FLAG     8'h0c
`define CSTB_OFF_IRQEN    8'h10
`define CSTB_OFF_SENSE0   8'h14
`define CSTB_OFF_SENSE1   8'h18
`define CSTB_OFF_C1CTL    8'h1c
`define CSTB_OFF_GATE     8'h20
`define CSTB_OFF_OPTION   8'h24

`define CSTB_PT_POST_MSB  6
`define CSTB_PT_POST_LSB  3
`define CSTB_PT_ON        2
`define CSTB_PT_PRE_MSB   1
`define CSTB_MATCH_BIT    1
`define CSTB_S0_ENABLE    7
`define CSTB_S0_RNG_MSB   3
`define CSTB_S0_RNG_LSB   2
`define CSTB_S0_PHASE     1
`define CSTB_S0_C0EXT     0
`define CSTB_S1_CH_MSB    3
`define CSTB_C1_CS_MSB    7
`define CSTB_C1_CS_LSB    6
`define CSTB_C1_ON        0
`define CSTB_G_ENABLE     7
`define CSTB_G_TOGGLE     5
`define CSTB_G_VALUE      2
`define CSTB_G_SRC_MSB    1
`define CSTB_OPT_C0CS     5

`define CSTB_RST_ZERO     8'h00
`define CSTB_RST_PERIOD   8'hff
`define CSTB_RST_C0CS     1'b1

`define CSTB_PRE_LAST1    4'h0
`define CSTB_PRE_LAST4    4'h3
`define CSTB_PRE_LAST16   4'hf
`define CSTB_RNG_OFF      2'b00
`define CSTB_C1_CS_OSC    2'b11
`define CSTB_GS_PIN       2'b00
`define CSTB_GS_C0OVF     2'b01
`define CSTB_GS_PERIOD    2'b10
`define CSTB_GS_WDT       2'b11
`define CSTB_RESP_OKAY    2'b00
`define CSTB_RESP_SLVERR  2'b10

`endif

// file: core/cstb_period_timer.v
// 8-bit period timer with prescaler, compare and postscaler
`timescale 1ns/1ps
`default_nettype none
`include "cstb_defs.vh"
module cstb_period_timer (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       timer_on_i,
	input  wire [1:0] prescale_sel_i,
	input  wire [3:0] postscale_sel_i,
	input  wire [7:0] period_i,
	input  wire       count_wr_i,
	input  wire [7:0] count_wdata_i,
	input  wire       ctrl_wr_i,
	output reg  [7:0] count_o,
	output reg        match_pulse_o
);

	reg  [3:0] presc_cnt;
	reg  [3:0] post_cnt;
	wire       tick;

	// terminal count of the prescaler for each select code
	function [3:0] presc_last(input [1:0] sel);
		begin
			case (sel)
			2'b00: presc_last = `CSTB_PRE_LAST1;
			2'b01: presc_last = `CSTB_PRE_LAST4;
			default: presc_last = `CSTB_PRE_LAST16;
			endcase
		end
	endfunction

	assign tick = timer_on_i && (presc_cnt == presc_last(prescale_sel_i));

	////////////////////////////////////////////////////////////////////////
	// count, compare and postscale; writes restart the scalers
	always @(posedge clk_i) begin
		if (rst_i) begin
			count_o       <= `CSTB_RST_ZERO;
			presc_cnt     <= 4'h0;
			post_cnt      <= 4'h0;
			match_pulse_o <= 1'b0;
		end else begin
			match_pulse_o <= 1'b0;
			if (count_wr_i) begin
				count_o   <= count_wdata_i;
				presc_cnt <= 4'h0;
				post_cnt  <= 4'h0;
			end else if (ctrl_wr_i) begin
				presc_cnt <= 4'h0; // count kept on purpose
				post_cnt  <= 4'h0;
			end else if (timer_on_i) begin
				if (!tick) begin
					presc_cnt <= presc_cnt + 4'h1;
				end else begin
					presc_cnt <= 4'h0;
					if (count_o == period_i) begin
						count_o <= 8'h00;
						if (post_cnt == postscale_sel_i) begin
							post_cnt      <= 4'h0;
							match_pulse_o <= 1'b1;
						end else begin
							post_cnt <= post_cnt + 4'h1;
						end
					end else begin
						count_o <= count_o + 8'h01;
					end
				end
			end
		end
	end

endmodule
`default_nettype wire

// file: core/cstb_gate.v
// counter1 gate source select, toggle flip-flop and count enable
`timescale 1ns/1ps
`default_nettype none
`include "cstb_defs.vh"
module cstb_gate (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       counter_on_i,
	input  wire       gate_enable_i,
	input  wire       toggle_mode_i,
	input  wire [1:0] source_sel_i,
	input  wire       gate_pin_i,
	input  wire       c0_ovf_i,
	input  wire       period_match_i,
	input  wire       wdt_ovf_i,
	output wire       gate_value_o,
	output wire       count_enable_o
);

	reg  src;
	reg  src_last;
	reg  toggle;

	// gate source selector
	always @* begin
		case (source_sel_i)
		`CSTB_GS_PIN:    src = gate_pin_i;
		`CSTB_GS_C0OVF:  src = c0_ovf_i;
		`CSTB_GS_PERIOD: src = period_match_i;
		default:         src = wdt_ovf_i;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// toggle flop flips on each rising source edge; off clears it
	always @(posedge clk_i) begin
		if (rst_i) begin
			src_last <= 1'b0;
			toggle   <= 1'b0;
		end else begin
			src_last <= src;
			if (!counter_on_i || !toggle_mode_i)
				toggle <= 1'b0;
			else if (src && !src_last)
				toggle <= ~toggle;
		end
	end

	assign gate_value_o   = toggle_mode_i ? toggle : src;
	// enable table: off, off, on, gated
	assign count_enable_o = counter_on_i && (!gate_enable_i || gate_value_o);

endmodule
`default_nettype wire

// file: core/cstb_top.v
// cap sense time base: register slave, sense mux control, counter clock routing
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cstb_defs.vh"
module cstb_top (
	input  wire        CLK_I,
	input  wire        RESET_I,
	// axi4-lite slave
	input  wire [7:0]  S_AXI_AWADDR_I,
	input  wire        S_AXI_AWVALID_I,
	output wire        S_AXI_AWREADY_O,
	input  wire [31:0] S_AXI_WDATA_I,
	input  wire [3:0]  S_AXI_WSTRB_I,
	input  wire        S_AXI_WVALID_I,
	output wire        S_AXI_WREADY_O,
	output reg  [1:0]  S_AXI_BRESP_O,
	output reg         S_AXI_BVALID_O,
	input  wire        S_AXI_BREADY_I,
	input  wire [7:0]  S_AXI_ARADDR_I,
	input  wire        S_AXI_ARVALID_I,
	output wire        S_AXI_ARREADY_O,
	output reg  [31:0] S_AXI_RDATA_O,
	output reg  [1:0]  S_AXI_RRESP_O,
	output reg         S_AXI_RVALID_O,
	input  wire        S_AXI_RREADY_I,
	// analog oscillator side
	input  wire        OSC_I,
	input  wire        OSC_PHASE_I,
	output wire [15:0] SENSE_PIN_SEL_O,
	output wire [1:0]  OSC_RANGE_O,
	output wire        OSC_RUN_O,
	// counter side
	output wire        C0_OSC_CLK_O,
	output wire        C1_OSC_CLK_O,
	output wire        C1_COUNT_EN_O,
	input  wire        GATE_PIN_I,
	input  wire        C0_OVF_I,
	input  wire        WDT_OVF_I,
	output wire        PERIOD_MATCH_PULSE_O,
	output wire        PERIOD_MATCH_IRQ_O
);

	// software registers
	reg  [3:0]  postscale_select;
	reg         period_timer_on;
	reg  [1:0]  prescale_select;
	reg  [7:0]  period_compare_value;
	reg         period_match_flag;
	reg         period_match_irq_enable;
	reg         sense_module_enable;
	reg  [1:0]  osc_current_range;
	reg         counter0_ext_source_select;
	reg  [3:0]  sense_channel_select;
	reg  [1:0]  counter1_clock_select;
	reg         counter1_on;
	reg         counter1_gate_enable;
	reg         gate_toggle_mode;
	reg  [1:0]  gate_source_select;
	reg         counter0_clock_select;

	// bus state
	reg         aw_got;
	reg         w_got;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg         w_lane0;
	wire        do_write;
	wire        wr_byte;
	wire [7:0]  wd;
	wire        wr_ptctl;
	wire        wr_count;
	wire [7:0]  period_timer_count;
	wire        match_pulse;
	wire        gate_value;
	reg  [7:0]  rd_byte;

	////////////////////////////////////////////////////////////////////////
	// address decode shared by the read and write paths
	function is_mapped(input [7:0] a);
		begin
			case (a)
			`CSTB_OFF_PTCTL, `CSTB_OFF_PERIOD, `CSTB_OFF_COUNT,
			`CSTB_OFF_FLAG, `CSTB_OFF_IRQEN, `CSTB_OFF_SENSE0,
			`CSTB_OFF_SENSE1, `CSTB_OFF_C1CTL, `CSTB_OFF_GATE,
			`CSTB_OFF_OPTION:
				is_mapped = 1'b1;
			default:
				is_mapped = 1'b0;
			endcase
		end
	endfunction

	// word index only: the low two address bits are ignored
	function is_reg(input [7:0] a, input [7:0] off);
		begin
			is_reg = ({a[7:2], 2'b00} == off);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in any order, one at a time
	assign S_AXI_AWREADY_O = !aw_got && !S_AXI_BVALID_O;
	assign S_AXI_WREADY_O  = !w_got && !S_AXI_BVALID_O;
	assign do_write        = aw_got && w_got && !S_AXI_BVALID_O;
	// registers are one byte wide, so only lane 0 carries a write
	assign wr_byte  = do_write && w_lane0 && is_mapped({aw_addr[7:2], 2'b00});
	assign wd       = w_data[7:0];
	assign wr_ptctl = wr_byte && is_reg(aw_addr, `CSTB_OFF_PTCTL);
	assign wr_count = wr_byte && is_reg(aw_addr, `CSTB_OFF_COUNT);

	always @(posedge CLK_I) begin
		if (RESET_I) begin
			aw_got         <= 1'b0;
			w_got          <= 1'b0;
			aw_addr        <= 8'h00;
			w_data         <= 32'h0000_0000;
			w_lane0        <= 1'b0;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O  <= `CSTB_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_got  <= 1'b1;
				aw_addr <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_got   <= 1'b1;
				w_data  <= S_AXI_WDATA_I;
				w_lane0 <= S_AXI_WSTRB_I[0];
			end
			if (do_write) begin
				aw_got         <= 1'b0;
				w_got          <= 1'b0;
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O  <= is_mapped({aw_addr[7:2], 2'b00}) ?
				                  `CSTB_RESP_OKAY : `CSTB_RESP_SLVERR;
			end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file; the period timer count itself lives in the timer
	always @(posedge CLK_I) begin
		if (RESET_I) begin
			postscale_select           <= 4'h0;
			period_timer_on            <= 1'b0;
			prescale_select            <= 2'b00;
			period_compare_value       <= `CSTB_RST_PERIOD;
			period_match_irq_enable    <= 1'b0;
			sense_module_enable        <= 1'b0;
			osc_current_range          <= `CSTB_RNG_OFF;
			counter0_ext_source_select <= 1'b0;
			sense_channel_select       <= 4'h0;
			counter1_clock_select      <= 2'b00;
			counter1_on                <= 1'b0;
			counter1_gate_enable       <= 1'b0;
			gate_toggle_mode           <= 1'b0;
			gate_source_select         <= `CSTB_GS_PIN;
			counter0_clock_select      <= `CSTB_RST_C0CS;
		end else if (wr_byte) begin
			case ({aw_addr[7:2], 2'b00})
			`CSTB_OFF_PTCTL: begin
				// bit 7 has no storage behind it
				postscale_select <= wd[`CSTB_PT_POST_MSB:`CSTB_PT_POST_LSB];
				period_timer_on  <= wd[`CSTB_PT_ON];
				prescale_select  <= wd[`CSTB_PT_PRE_MSB:0];
			end
			`CSTB_OFF_PERIOD: period_compare_value <= wd;
			`CSTB_OFF_IRQEN:  period_match_irq_enable <= wd[`CSTB_MATCH_BIT];
			`CSTB_OFF_SENSE0: begin
				sense_module_enable        <= wd[`CSTB_S0_ENABLE];
				osc_current_range          <= wd[`CSTB_S0_RNG_MSB:`CSTB_S0_RNG_LSB];
				counter0_ext_source_select <= wd[`CSTB_S0_C0EXT];
			end
			`CSTB_OFF_SENSE1: sense_channel_select <= wd[`CSTB_S1_CH_MSB:0];
			`CSTB_OFF_C1CTL: begin
				counter1_clock_select <= wd[`CSTB_C1_CS_MSB:`CSTB_C1_CS_LSB];
				counter1_on           <= wd[`CSTB_C1_ON];
			end
			`CSTB_OFF_GATE: begin
				counter1_gate_enable <= wd[`CSTB_G_ENABLE];
				gate_toggle_mode     <= wd[`CSTB_G_TOGGLE];
				gate_source_select   <= wd[`CSTB_G_SRC_MSB:0];
			end
			`CSTB_OFF_OPTION: counter0_clock_select <= wd[`CSTB_OPT_C0CS];
			default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// match flag: a match in the same cycle as a software clear still sets it
	always @(posedge CLK_I) begin
		if (RESET_I)
			period_match_flag <= 1'b0;
		else if (match_pulse)
			period_match_flag <= 1'b1;
		else if (wr_byte && is_reg(aw_addr, `CSTB_OFF_FLAG))
			period_match_flag <= wd[`CSTB_MATCH_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// read channel: one read at a time, answered the cycle after it is taken
	assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

	always @* begin
		rd_byte = 8'h00;
		case ({S_AXI_ARADDR_I[7:2], 2'b00})
		`CSTB_OFF_PTCTL:  rd_byte = {1'b0, postscale_select, period_timer_on,
		                             prescale_select};
		`CSTB_OFF_PERIOD: rd_byte = period_compare_value;
		`CSTB_OFF_COUNT:  rd_byte = period_timer_count;
		`CSTB_OFF_FLAG:   rd_byte = {6'h00, period_match_flag, 1'b0};
		`CSTB_OFF_IRQEN:  rd_byte = {6'h00, period_match_irq_enable, 1'b0};
		`CSTB_OFF_SENSE0: rd_byte = {sense_module_enable, 3'h0, osc_current_range,
		                             OSC_PHASE_I, counter0_ext_source_select};
		`CSTB_OFF_SENSE1: rd_byte = {4'h0, sense_channel_select};
		`CSTB_OFF_C1CTL:  rd_byte = {counter1_clock_select, 5'h00, counter1_on};
		`CSTB_OFF_GATE:   rd_byte = {counter1_gate_enable, 1'b0, gate_toggle_mode,
		                             2'b00, gate_value, gate_source_select};
		`CSTB_OFF_OPTION: rd_byte = {2'b00, counter0_clock_select, 5'h00};
		default:          rd_byte = 8'h00;
		endcase
	end

	always @(posedge CLK_I) begin
		if (RESET_I) begin
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O  <= 32'h0000_0000;
			S_AXI_RRESP_O  <= `CSTB_RESP_OKAY;
		end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			S_AXI_RVALID_O <= 1'b1;
			S_AXI_RDATA_O  <= {24'h00_0000, rd_byte};
			S_AXI_RRESP_O  <= is_mapped({S_AXI_ARADDR_I[7:2], 2'b00}) ?
			                  `CSTB_RESP_OKAY : `CSTB_RESP_SLVERR;
		end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
			S_AXI_RVALID_O <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// period timer; its match pulse feeds flag and gate selector alike
	cstb_period_timer i_cstb_period_timer (
		.clk_i           (CLK_I),
		.rst_i           (RESET_I),
		.timer_on_i      (period_timer_on),
		.prescale_sel_i  (prescale_select),
		.postscale_sel_i (postscale_select),
		.period_i        (period_compare_value),
		.count_wr_i      (wr_count),
		.count_wdata_i   (wd),
		.ctrl_wr_i       (wr_ptctl),
		.count_o         (period_timer_count),
		.match_pulse_o   (match_pulse)
	);

	// counter1 gate built from the selected source: gate pin, counter0 overflow, period match or watchdog overflow
	cstb_gate i_cstb_gate (
		.clk_i          (CLK_I),
		.rst_i          (RESET_I),
		.counter_on_i   (counter1_on),
		.gate_enable_i  (counter1_gate_enable),
		.toggle_mode_i  (gate_toggle_mode),
		.source_sel_i   (gate_source_select),
		.gate_pin_i     (GATE_PIN_I),
		.c0_ovf_i       (C0_OVF_I),
		.period_match_i (match_pulse),
		.wdt_ovf_i      (WDT_OVF_I),
		.gate_value_o   (gate_value),
		.count_enable_o (C1_COUNT_EN_O)
	);

	assign PERIOD_MATCH_PULSE_O = match_pulse;
	assign PERIOD_MATCH_IRQ_O   = period_match_flag && period_match_irq_enable;

	////////////////////////////////////////////////////////////////////////
	// sense mux and oscillator control; nothing is selected while disabled
	assign SENSE_PIN_SEL_O = sense_module_enable ?
	                         (16'h0001 << sense_channel_select) : 16'h0000;
	assign OSC_RANGE_O     = sense_module_enable ? osc_current_range : `CSTB_RNG_OFF;
	// range 00 keeps the oscillator stopped even with the module on
	assign OSC_RUN_O       = sense_module_enable &&
	                         (osc_current_range != `CSTB_RNG_OFF);

	// counter clock routing; the oscillator is passed, not resampled
	assign C0_OSC_CLK_O = counter0_ext_source_select && !counter0_clock_select &&
	                      OSC_I;
	assign C1_OSC_CLK_O = (counter1_clock_select == `CSTB_C1_CS_OSC) && OSC_I;

endmodule
`default_nettype wire

// file: tb/cstb_properties.sv
// port checker of the cap sense time base, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module cstb_properties (
	input wire logic        CLK_I,
	input wire logic        RESET_I,
	input wire logic [7:0]  S_AXI_ARADDR_I,
	input wire logic        S_AXI_ARVALID_I,
	input wire logic        S_AXI_ARREADY_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic        S_AXI_RVALID_O,
	input wire logic        S_AXI_RREADY_I,
	input wire logic [1:0]  S_AXI_BRESP_O,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_BREADY_I,
	input wire logic        OSC_I,
	input wire logic [15:0] SENSE_PIN_SEL_O,
	input wire logic [1:0]  OSC_RANGE_O,
	input wire logic        OSC_RUN_O,
	input wire logic        C0_OSC_CLK_O,
	input wire logic        C1_OSC_CLK_O,
	input wire logic        PERIOD_MATCH_PULSE_O,
	input wire logic        PERIOD_MATCH_IRQ_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	logic [7:0] rd_addr;
	////////////////////////////////////////////////////////////////////////////////
	// remember the read address, the data comes a cycle after it is taken
	always @(posedge CLK_I) begin
		if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) rd_addr <= S_AXI_ARADDR_I;
	end
	property p_bit7_zero;
		S_AXI_RVALID_O && rd_addr[7:2] == 6'h00 |-> !S_AXI_RDATA_O[7];
	endproperty
	a_bit7_zero: assert property (p_bit7_zero) else $error("control bit 7 read back as one");
	property p_pin_onehot;
		$onehot0(SENSE_PIN_SEL_O);
	endproperty
	a_pin_onehot: assert property (p_pin_onehot) else $error("more than one sense pin");
	property p_run_pin;
		OSC_RUN_O |-> SENSE_PIN_SEL_O != 16'h0000;
	endproperty
	a_run_pin: assert property (p_run_pin) else $error("oscillator runs on no pin");
	property p_range_run;
		(OSC_RANGE_O != 2'b00) == OSC_RUN_O;
	endproperty
	a_range_run: assert property (p_range_run) else $error("run and range disagree");
	property p_pulse_single;
		PERIOD_MATCH_PULSE_O |=> !PERIOD_MATCH_PULSE_O;
	endproperty
	a_pulse_single: assert property (p_pulse_single) else $error("match pulse too long");
	property p_c0_clk;
		C0_OSC_CLK_O |-> OSC_I;
	endproperty
	a_c0_clk: assert property (p_c0_clk) else $error("counter0 clock not from oscillator");
	property p_c1_clk;
		C1_OSC_CLK_O |-> OSC_I;
	endproperty
	a_c1_clk: assert property (p_c1_clk) else $error("counter1 clock not from oscillator");
	property p_irq_reset;
		$fell(RESET_I) |-> !PERIOD_MATCH_IRQ_O;
	endproperty
	a_irq_reset: assert property (p_irq_reset) else $error("match request set after reset");
	property p_rd_answer;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered in one cycle");
	property p_r_hold;
		S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped before taken");
	property p_b_hold;
		S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped before taken");
	c_pulse: cover property (PERIOD_MATCH_PULSE_O);
	c_c1_clk: cover property (C1_OSC_CLK_O);
	c_read: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
endmodule
bind cstb_top cstb_properties u_chk (.CLK_I(CLK_I), .RESET_I(RESET_I),
	.S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
	.S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
	.S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
	.S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
	.S_AXI_BREADY_I(S_AXI_BREADY_I), .OSC_I(OSC_I), .SENSE_PIN_SEL_O(SENSE_PIN_SEL_O),
	.OSC_RANGE_O(OSC_RANGE_O), .OSC_RUN_O(OSC_RUN_O), .C0_OSC_CLK_O(C0_OSC_CLK_O),
	.C1_OSC_CLK_O(C1_OSC_CLK_O), .PERIOD_MATCH_PULSE_O(PERIOD_MATCH_PULSE_O),
	.PERIOD_MATCH_IRQ_O(PERIOD_MATCH_IRQ_O));
`default_nettype wire

// file: tb/cstb_pad_model.sv
// touch pad with its relaxation oscillator on the selected sense pin
`timescale 1ns/1ps
`default_nettype none
module cstb_pad_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] pin_sel_i,
	input  wire logic [1:0]  range_i,
	input  wire logic        run_i,
	output var  logic        osc_o,
	output var  logic        phase_o
);
	logic [2:0] half_cnt;
	initial begin
		osc_o = 1'b0;
		phase_o = 1'b0;
		half_cnt = 3'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// more current charges the pad faster, so the half period shrinks with range;
	// a stopped oscillator holds its last level, it is not a released line
	always @(posedge clk_i) begin
		if (run_i && pin_sel_i != 16'h0000) begin
			if (half_cnt + {1'b0, range_i} >= 3'h3) begin
				osc_o <= ~osc_o;
				phase_o <= ~phase_o;
				half_cnt <= 3'h0;
			end else begin
				half_cnt <= half_cnt + 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/test_cap_sense_count_timebase.sv
// self-checking bench of the cap sense time base
`timescale 1ns/1ps
`default_nettype none
`include "cstb_defs.vh"
module test_cap_sense_count_timebase;
	logic        clk = 1'b0, rst = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        gate_pin = 1'b0, wdt_ovf = 1'b0;
	wire         awready, wready, bvalid, arready, rvalid, osc, phase, run, c0clk, c1clk;
	wire         c1en, pulse, irq;
	wire [1:0]   bresp, rresp, range;
	wire [31:0]  rdata;
	wire [15:0]  pin_sel;
	int          error_cnt = 0, samples_checked = 0, c, o, n0, n1;
	logic [31:0] d;
	logic [1:0]  r;
	logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
	logic [7:0]  re [10] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
	int          pre_div [4] = '{1, 4, 16, 16};
	cstb_top i_cstb_top (.CLK_I(clk), .RESET_I(rst), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .OSC_I(osc), .OSC_PHASE_I(phase), .SENSE_PIN_SEL_O(pin_sel),
		.OSC_RANGE_O(range), .OSC_RUN_O(run), .C0_OSC_CLK_O(c0clk), .C1_OSC_CLK_O(c1clk),
		.C1_COUNT_EN_O(c1en), .GATE_PIN_I(gate_pin), .C0_OVF_I(1'b0), .WDT_OVF_I(wdt_ovf),
		.PERIOD_MATCH_PULSE_O(pulse), .PERIOD_MATCH_IRQ_O(irq));
	cstb_pad_model i_pad (.clk_i(clk), .pin_sel_i(pin_sel), .range_i(range), .run_i(run),
		.osc_o(osc), .phase_o(phase));
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic check_val(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// write: address and data offered together, each released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] s);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready) && n < 100);
		if (!(bvalid && bready)) error_cnt++; // a write that never answers counts as a mismatch
		s = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready) && n < 100);
		if (!(rvalid && rready)) error_cnt++; // a read that never answers counts as a mismatch
		v = rdata;
		s = rresp;
		rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [1:0] s;
		axi_wr(a, v, s);
		check_val("write resp", s, 32'h0);
	endtask
	task automatic rd_chk(input string w, input logic [7:0] a, input logic [7:0] e);
		logic [31:0] v;
		logic [1:0]  s;
		axi_rd(a, v, s);
		check_val(w, v, {24'h0, e});
		check_val("read resp", s, 32'h0);
	endtask
	// cycles from one match pulse to the next; the first gap after a write is skipped
	task automatic gap(output int g);
		int n;
		n = 0;
		while (!pulse && n < 3000) begin
			@(posedge clk);
			n++;
		end
		g = 0;
		do begin
			@(posedge clk);
			g++;
		end while (!pulse && g < 3000);
	endtask
	// high cycles of the oscillator and of both counter clocks over a fixed window
	task automatic clk_sum;
		o = 0;
		n0 = 0;
		n1 = 0;
		repeat (40) begin
			@(negedge clk);
			o += osc;
			n0 += c0clk;
			n1 += c1clk;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#2000000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 10; i++) rd_chk("reset value", ra[i], re[i]);
		axi_rd(8'h40, d, r);
		check_val("unmapped read resp", r, 32'h2);
		check_val("unmapped read data", d, 32'h0);
		axi_wr(8'h40, 8'h5a, r);
		check_val("unmapped write resp", r, 32'h2);
		// stopped timer keeps a loaded count, a control write leaves it alone
		wr(8'h04, 8'h03);
		wr(8'h08, 8'h05);
		repeat (20) @(posedge clk);
		rd_chk("count while stopped", 8'h08, 8'h05);
		wr(8'h00, 8'h78);
		rd_chk("count after control write", 8'h08, 8'h05);
		wr(8'h00, 8'hff);
		rd_chk("control readback", 8'h00, 8'h7f);
		// period 3 gives four ticks a match
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, 8'h04 | i[7:0]);
			gap(c);
			check_val("prescaled gap", c, 4 * pre_div[i]);
		end
		for (int k = 1; k < 16; k += 14) begin
			wr(8'h00, {1'b0, k[3:0], 3'b100});
			gap(c);
			check_val("postscaled gap", c, 4 * (k + 1));
		end
		wr(8'h10, 8'h02);
		rd_chk("match flag", 8'h0c, 8'h02);
		@(negedge clk);
		check_val("match request", irq, 32'h1);
		wr(8'h00, 8'h00);
		wr(8'h0c, 8'h00);
		rd_chk("flag cleared", 8'h0c, 8'h00);
		check_val("request cleared", irq, 32'h0);
		// every channel, then every range
		wr(8'h14, 8'h84);
		for (int ch = 0; ch < 16; ch++) begin
			wr(8'h18, ch[7:0]);
			@(negedge clk);
			check_val("pin select", pin_sel, 32'h1 << ch);
		end
		for (int g = 0; g < 4; g++) begin
			wr(8'h14, 8'h80 | (g[7:0] << 2));
			@(negedge clk);
			check_val("range", range, g);
			check_val("run", run, 32'(g != 0));
		end
		// at range 3 the oscillator flips phase every cycle; stop it so the read is comparable
		wr(8'h14, 8'h80);
		axi_rd(8'h14, d, r);
		check_val("phase status", d[1], phase);
		wr(8'h14, 8'h00);
		@(negedge clk);
		check_val("pins off", pin_sel, 32'h0);
		// oscillator routed to counter0 and counter1 together, then to neither, software picks the path
		wr(8'h14, 8'h8d);
		wr(8'h24, 8'h00);
		wr(8'h1c, 8'hc1);
		clk_sum();
		check_val("oscillator ran", 32'(o != 0), 32'h1);
		check_val("counter0 clock", n0, o);
		check_val("counter1 clock", n1, o);
		wr(8'h24, 8'h20);
		wr(8'h1c, 8'h01);
		clk_sum();
		check_val("counter0 clock off", n0, 0);
		check_val("counter1 clock off", n1, 0);
		// counter1 enable: off, free, pin gate, then toggle gate on watchdog overflow
		wr(8'h1c, 8'h00);
		check_val("c1 off", c1en, 32'h0);
		wr(8'h1c, 8'h01);
		check_val("c1 free", c1en, 32'h1);
		wr(8'h20, 8'h80);
		check_val("c1 gate closed", c1en, 32'h0);
		gate_pin <= 1'b1;
		@(negedge clk);
		check_val("c1 gate open", c1en, 32'h1);
		wr(8'h20, 8'ha3);
		check_val("toggle cleared", c1en, 32'h0);
		@(posedge clk);
		wdt_ovf <= 1'b1;
		@(posedge clk);
		wdt_ovf <= 1'b0;
		repeat (4) @(posedge clk);
		rd_chk("gate value", 8'h20, 8'ha7);
		check_val("toggle open", c1en, 32'h1);
		// period match as gate source: each match pulse flips the toggle flop
		wr(8'h20, 8'ha2);
		wr(8'h00, 8'h04);
		@(posedge clk iff pulse);
		d[0] = c1en;
		@(negedge clk);
		check_val("period gate flip", c1en, {31'h0, !d[0]});
		// a second reset restores the compare value
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd_chk("compare after reset", 8'h04, 8'hff);
		tally_and_finish();
	end
endmodule
`default_nettype wire
